// ===== src/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

	// ****************************************************************
	// Configuration-space layout
	// ****************************************************************

	// Dword that holds the command half (lanes 1:0) and status half (lanes 3:2).
	localparam logic [7:0]  CFG_CMD_STS_DWORD  = 8'h04;
	localparam logic [7:0]  CMD_OFFSET         = 8'h04;
	localparam logic [7:0]  STS_OFFSET         = 8'h06;

	// Command bit positions.
	localparam int          CMD_IO_EN_BIT      = 0;
	localparam int          CMD_MEM_EN_BIT     = 1;
	localparam int          CMD_BUS_INIT_BIT   = 2;
	localparam int          CMD_SPECIAL_BIT    = 3;
	localparam int          CMD_WI_PROMOTE_BIT = 4;
	localparam int          CMD_PARITY_RSP_BIT = 6;
	localparam int          CMD_ERR_REPORT_BIT = 8;

	// Writable command bits and value after reset.
	localparam logic [15:0] CMD_WRITE_MASK     = 16'h0157;
	localparam logic [15:0] CMD_RESET_VALUE    = 16'h0000;

	// Status bit positions.
	localparam int          STS_DATA_PARITY_BIT    = 8;
	localparam int          STS_CA_SIGNALLED_BIT   = 11;
	localparam int          STS_CA_RECEIVED_BIT    = 12;
	localparam int          STS_UR_RECEIVED_BIT    = 13;
	localparam int          STS_SYSTEM_ERROR_SIGNALLED_BIT        = 14;
	localparam int          STS_POISON_BIT         = 15;

	// Read/clear status bits, constant ones and value after reset.
	localparam logic [15:0] STS_CLEAR_MASK     = 16'hF900;
	localparam logic [15:0] STS_FIXED_ONES     = 16'h0010;
	localparam logic [15:0] STS_RESET_VALUE    = 16'h0010;

endpackage : bridge_cfg_pkg

// ===== src/pcie_bridge_cmd_status_regs.sv
module pcie_bridge_cmd_status_regs
	import bridge_cfg_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Configuration access port.
	input  wire logic        cfg_req,
	input  wire logic        cfg_we,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic      [31:0] cfg_rdata,
	// Downstream requests from PCIe.
	input  wire logic        dn_req_valid,
	input  wire logic        dn_req_mem,
	input  wire logic        dn_req_io,
	input  wire logic        dn_req_write,
	output logic             dn_fwd,
	output logic             dn_fwd_invalidate,
	output logic             dn_unsupported,
	// Secondary PCI requests and PCIe initiation.
	input  wire logic        up_req_valid,
	input  wire logic        up_req_mem_io,
	output logic             up_claim,
	input  wire logic        tx_req,
	output logic             tx_grant,
	// Error message control.
	input  wire logic        pci_serr_seen,
	output logic             err_msg_request,
	// Status events.
	input  wire logic        ev_poisoned_tlp,
	input  wire logic        ev_err_msg_sent,
	input  wire logic        ev_cpl_ur_received,
	input  wire logic        ev_cpl_ca_received,
	input  wire logic        ev_cpl_ca_sent,
	input  wire logic        ev_data_poison,
	// Command levels for the rest of the bridge.
	output logic             write_invalidate_promote_en,
	output logic             bus_initiator_en,
	output logic             mem_space_en,
	output logic             io_space_en,
	output logic             error_report_en,
	output logic             parity_response_en
);

	// ****************************************************************
	// Access decode
	// ****************************************************************

	logic        hit;
	logic        wr_hit;
	logic [15:0] cmd_lane_mask;
	logic [15:0] sts_lane_mask;

	// Expands two byte enables into a 16-bit lane mask.
	function automatic logic [15:0] lanes16(input logic [1:0] be);
		lanes16 = {{8{be[1]}}, {8{be[0]}}};
	endfunction : lanes16

	// Only the command/status dword is mapped; other dwords read zero.
	always_comb begin
		hit           = (cfg_addr[7:2] == CFG_CMD_STS_DWORD[7:2]);
		wr_hit        = cfg_req && cfg_we && hit;
		cmd_lane_mask = lanes16(cfg_be[1:0]);
		sts_lane_mask = lanes16(cfg_be[3:2]);
	end

	// ****************************************************************
	// Command register
	// ****************************************************************

	logic [15:0] cmd_reg;
	logic [15:0] cmd_next;

	// Only the writable bits take write data, so bit 3 stays zero.
	always_comb begin
		cmd_next = cmd_reg;
		if (wr_hit) begin
			cmd_next = (cmd_reg & ~(cmd_lane_mask & CMD_WRITE_MASK))
				| (cfg_wdata[15:0] & cmd_lane_mask & CMD_WRITE_MASK);
		end
	end

	// Command flip-flops; all enables start cleared.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd_reg <= CMD_RESET_VALUE;
		end else begin
			cmd_reg <= cmd_next;
		end
	end

	assign write_invalidate_promote_en = cmd_reg[CMD_WI_PROMOTE_BIT];
	assign bus_initiator_en            = cmd_reg[CMD_BUS_INIT_BIT];
	assign mem_space_en                = cmd_reg[CMD_MEM_EN_BIT];
	assign io_space_en                 = cmd_reg[CMD_IO_EN_BIT];
	assign error_report_en             = cmd_reg[CMD_ERR_REPORT_BIT];
	assign parity_response_en          = cmd_reg[CMD_PARITY_RSP_BIT];

	// ****************************************************************
	// Transaction gating
	// ****************************************************************

	// A downstream request of a disabled space is answered unsupported.
	always_comb begin
		dn_fwd = dn_req_valid
			&& ((dn_req_mem && mem_space_en) || (dn_req_io && io_space_en));
		dn_unsupported = dn_req_valid
			&& ((dn_req_mem && !mem_space_en) || (dn_req_io && !io_space_en));
		dn_fwd_invalidate = dn_fwd && dn_req_mem && dn_req_write
			&& write_invalidate_promote_en;
	end

	// Upstream traffic needs the initiator enable; error messages need the error report enable.
	always_comb begin
		up_claim        = up_req_valid && up_req_mem_io && bus_initiator_en;
		tx_grant        = tx_req && bus_initiator_en;
		err_msg_request = pci_serr_seen && error_report_en;
	end

	// ****************************************************************
	// Status register
	// ****************************************************************

	logic [15:0] sts_set;
	logic [15:0] sts_clr;
	logic [15:0] sts_flags;
	logic [15:0] sts_value;

	// Events map onto their bit positions; clears come from one-writes.
	always_comb begin
		sts_set                        = '0;
		sts_set[STS_POISON_BIT]        = ev_poisoned_tlp;
		sts_set[STS_SYSTEM_ERROR_SIGNALLED_BIT]       = ev_err_msg_sent && error_report_en;
		sts_set[STS_UR_RECEIVED_BIT]   = ev_cpl_ur_received;
		sts_set[STS_CA_RECEIVED_BIT]   = ev_cpl_ca_received;
		sts_set[STS_CA_SIGNALLED_BIT]  = ev_cpl_ca_sent;
		sts_set[STS_DATA_PARITY_BIT]   = ev_data_poison && parity_response_en;
		sts_clr = wr_hit ? (cfg_wdata[31:16] & sts_lane_mask & STS_CLEAR_MASK)
			: 16'h0000;
	end

	sticky_flag_bank #(
		.WIDTH (16)
	) u_flags (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.flag_set (sts_set),
		.flag_clr (sts_clr),
		.flag_q   (sts_flags)
	);

	// The capability bit is a constant one; other bits read zero.
	assign sts_value = (sts_flags & STS_CLEAR_MASK) | STS_FIXED_ONES;

	// ****************************************************************
	// Read data and acknowledge
	// ****************************************************************

	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        ack_reg;
	logic        ack_next;

	// Reads return the values before any write in the same cycle.
	always_comb begin
		ack_next   = cfg_req;
		rdata_next = rdata_reg;
		if (cfg_req) begin
			rdata_next = (hit && !cfg_we) ? {sts_value, cmd_reg} : 32'h0000_0000;
		end
	end

	// Answer flip-flops; every access is acknowledged one cycle later.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	assign cfg_ack   = ack_reg;
	assign cfg_rdata = rdata_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************

	logic        rd_taken_reg;
	logic        rd_taken_next;

	// Remembers that the answer now standing belongs to a mapped read.
	always_comb begin
		rd_taken_next = cfg_req && !cfg_we && hit;
	end

	// Tracking flip-flop for the checks only; it changes no behaviour.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_taken_reg <= 1'b0;
		end else begin
			rd_taken_reg <= rd_taken_next;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	wi_promote_a: assert property (dn_req_valid && dn_req_mem && dn_req_write
		&& mem_space_en && write_invalidate_promote_en |-> dn_fwd_invalidate)
		else $error("memory write not promoted");
	special_zero_a: assert property (cfg_ack && rd_taken_reg
		|-> !cfg_rdata[CMD_SPECIAL_BIT])
		else $error("special cycle bit read as one");
	initiator_gate_a: assert property (tx_grant |-> bus_initiator_en && tx_req)
		else $error("initiation granted while disabled");
	sec_block_a: assert property (!bus_initiator_en |-> !up_claim)
		else $error("secondary request claimed while disabled");
	sec_fwd_a: assert property (up_req_valid && up_req_mem_io && bus_initiator_en
		|-> up_claim)
		else $error("secondary request not claimed");
	mem_ur_a: assert property (dn_req_valid && dn_req_mem && !mem_space_en
		|-> dn_unsupported && !dn_fwd)
		else $error("memory request not refused");
	mem_fwd_a: assert property (dn_req_valid && dn_req_mem && mem_space_en
		|-> dn_fwd)
		else $error("memory request not forwarded");
	io_ur_a: assert property (dn_req_valid && dn_req_io && !io_space_en
		|-> dn_unsupported && !dn_fwd)
		else $error("io request not refused");
	io_fwd_a: assert property (dn_req_valid && dn_req_io && io_space_en
		|-> dn_fwd)
		else $error("io request not forwarded");
	sts_reset_a: assert property (disable iff (1'b0) sys_rst ##1 !sys_rst
		|-> sts_value == STS_RESET_VALUE && cmd_reg == CMD_RESET_VALUE)
		else $error("bad value after reset");
	poison_set_a: assert property (ev_poisoned_tlp |=> sts_value[STS_POISON_BIT])
		else $error("poison flag not set");
	system_error_signalled_a: assert property (!($past(ev_err_msg_sent) && $past(error_report_en))
		&& !$past(sts_flags[STS_SYSTEM_ERROR_SIGNALLED_BIT]) |-> !sts_flags[STS_SYSTEM_ERROR_SIGNALLED_BIT])
		else $error("system error flag set without cause");
	ur_rcv_a: assert property (ev_cpl_ur_received |=> sts_value[STS_UR_RECEIVED_BIT])
		else $error("unsupported completion flag not set");
	ca_rcv_a: assert property (ev_cpl_ca_received |=> sts_value[STS_CA_RECEIVED_BIT])
		else $error("completer abort received flag not set");
	ca_sig_a: assert property (ev_cpl_ca_sent |=> sts_value[STS_CA_SIGNALLED_BIT])
		else $error("completer abort signalled flag not set");
	flag_clear_a: assert property (wr_hit && cfg_be[3] && cfg_wdata[31]
		&& !ev_poisoned_tlp |=> !sts_value[STS_POISON_BIT]
		##1 (!sts_value[STS_POISON_BIT] || $past(ev_poisoned_tlp)))
		else $error("write of one did not clear flag");
	cmd_write_a: assert property (wr_hit && cfg_be[0] |=> cmd_reg[7:0]
		== ($past(cfg_wdata[7:0]) & CMD_WRITE_MASK[7:0]))
		else $error("command low byte not written");
	parity_set_a: assert property (ev_data_poison && parity_response_en
		|=> sts_value[STS_DATA_PARITY_BIT])
		else $error("data parity flag not set");
	parity_hold_a: assert property (ev_data_poison && !parity_response_en
		&& !sts_flags[STS_DATA_PARITY_BIT] |=> !sts_flags[STS_DATA_PARITY_BIT])
		else $error("data parity flag set while disabled");
	system_error_signalled_set_a: assert property (ev_err_msg_sent && error_report_en
		|=> sts_value[STS_SYSTEM_ERROR_SIGNALLED_BIT])
		else $error("system error flag not set");
	err_msg_gate_a: assert property (err_msg_request
		|-> pci_serr_seen && error_report_en)
		else $error("error message requested while disabled");
	ack_timing_a: assert property (cfg_req |=> cfg_ack)
		else $error("access not acknowledged");
	ro_bits_a: assert property (cfg_ack && rd_taken_reg
		|-> (cfg_rdata[15:0] & ~CMD_WRITE_MASK) == 16'h0000
		&& (cfg_rdata[31:16] & ~STS_CLEAR_MASK) == STS_FIXED_ONES)
		else $error("read-only bits read wrong");

	mem_fwd_c: cover property (dn_fwd && dn_req_mem ##1 dn_fwd_invalidate);
	ur_c: cover property (dn_unsupported);
	system_error_signalled_c: cover property (ev_err_msg_sent && error_report_en);
	clear_c: cover property (sts_value[STS_POISON_BIT] ##1 wr_hit ##1
		!sts_value[STS_POISON_BIT]);
	set_clear_c: cover property (wr_hit && cfg_wdata[31] && ev_poisoned_tlp);

endmodule : pcie_bridge_cmd_status_regs

// ===== src/sticky_flag_bank.sv
// Bank of sticky flags; a set in the same cycle as a clear wins.
module sticky_flag_bank
	import bridge_cfg_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Hardware events and software clears.
	input  wire logic [WIDTH-1:0] flag_set,
	input  wire logic [WIDTH-1:0] flag_clr,
	// Current flags.
	output logic      [WIDTH-1:0] flag_q
);

	logic [WIDTH-1:0] flag_reg;
	logic [WIDTH-1:0] flag_next;

	// A pending event survives a clear that lands in the same cycle.
	always_comb begin
		flag_next = (flag_reg & ~flag_clr) | flag_set;
	end

	// Flags register.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_q = flag_reg;

endmodule : sticky_flag_bank

// ===== verification/cfg_host_model.sv
module cfg_host_model
	import bridge_cfg_pkg::*;
(
	// Clock.
	input  wire logic        core_clk,
	// Request side of the configuration port.
	output logic             cfg_req,
	output logic             cfg_we,
	output logic      [7:0]  cfg_addr,
	output logic      [3:0]  cfg_be,
	output logic      [31:0] cfg_wdata,
	// Answer side of the configuration port.
	input  wire logic        cfg_ack,
	input  wire logic [31:0] cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Configuration software
	// ****************************************************************

	// Idle values from time zero.
	initial begin
		cfg_req = 1'b0;
		cfg_we = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// One access: a single-cycle request, the answer is sampled once the ack has landed.
	task automatic access(input logic we, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd, output logic ack);
		@(posedge core_clk);
		cfg_req <= 1'b1;
		cfg_we <= we;
		cfg_addr <= addr;
		cfg_be <= be;
		cfg_wdata <= wd;
		@(posedge core_clk);
		cfg_req <= 1'b0;
		// Released data carries the inverse, so a stale value never passes for a live one.
		cfg_wdata <= ~wd;
		#1;
		ack = cfg_ack;
		rd = cfg_rdata;
	endtask : access

	// Software clears status flags by writing ones on the status lanes only.
	task automatic clear_flags(input logic [15:0] mask);
		logic [31:0] rd;
		logic        ack;
		access(1'b1, CFG_CMD_STS_DWORD, 4'b1100, {mask, 16'h0000}, rd, ack);
	endtask : clear_flags
endmodule : cfg_host_model

// ===== verification/pcie_bridge_cmd_status_regs_tb_top.sv
module pcie_bridge_cmd_status_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bridge_cfg_pkg::*;

	// ****************************************************************
	// Signals and instances
	// ****************************************************************

	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cfg_req, cfg_we, cfg_ack;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata;
	logic [3:0]  dn = 4'h0;     // Valid, memory, I/O, write.
	logic [3:0]  up = 4'h0;     // Valid, memory or I/O, initiation, secondary error.
	logic [5:0]  ev = 6'h00;    // Data poison, abort sent, abort rcvd, UR rcvd, msg, poison.
	wire  [5:0]  lvl;           // Promote, initiator, memory, I/O, report, parity.
	wire  [2:0]  dn_out;        // Forward, invalidate, unsupported.
	wire  [2:0]  up_out;        // Claim, grant, error message.
	int          fails = 0;
	int          comparisons = 0;

	cfg_host_model host (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_rdata(cfg_rdata));

	pcie_bridge_cmd_status_regs DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.dn_req_valid(dn[3]), .dn_req_mem(dn[2]), .dn_req_io(dn[1]), .dn_req_write(dn[0]),
		.dn_fwd(dn_out[2]), .dn_fwd_invalidate(dn_out[1]), .dn_unsupported(dn_out[0]),
		.up_req_valid(up[3]), .up_req_mem_io(up[2]), .up_claim(up_out[2]),
		.tx_req(up[1]), .tx_grant(up_out[1]), .pci_serr_seen(up[0]),
		.err_msg_request(up_out[0]), .ev_poisoned_tlp(ev[0]), .ev_err_msg_sent(ev[1]),
		.ev_cpl_ur_received(ev[2]), .ev_cpl_ca_received(ev[3]), .ev_cpl_ca_sent(ev[4]),
		.ev_data_poison(ev[5]), .write_invalidate_promote_en(lvl[5]),
		.bus_initiator_en(lvl[4]), .mem_space_en(lvl[3]), .io_space_en(lvl[2]),
		.error_report_en(lvl[1]), .parity_response_en(lvl[0]));

	// Free-running 125 MHz clock.
	initial begin
		forever #4 core_clk = ~core_clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [3:0] be, input logic [31:0] wd);
		logic [31:0] rdv;
		logic        ack;
		host.access(1'b1, CFG_CMD_STS_DWORD, be, wd, rdv, ack);
		chk("write ack", {31'h0, ack}, 32'h0000_0001);
		chk("write data", rdv, 32'h0000_0000);
	endtask : wr

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
		logic [31:0] got;
		logic        ack;
		host.access(1'b0, addr, 4'hF, 32'h0000_0000, got, ack);
		chk("read ack", {31'h0, ack}, 32'h0000_0001);
		chk(what, got, exp);
	endtask : rd

	// Gating outputs are combinational, so they are judged just after the inputs land.
	task automatic gate(input logic [3:0] d, input logic [3:0] u, input logic [2:0] ed,
		input logic [2:0] eu);
		@(posedge core_clk);
		dn <= d;
		up <= u;
		#1;
		chk("downstream gating", {29'h0, dn_out}, {29'h0, ed});
		chk("upstream gating", {29'h0, up_out}, {29'h0, eu});
	endtask : gate

	task automatic pulse(input logic [5:0] v);
		@(posedge core_clk);
		ev <= v;
		@(posedge core_clk);
		ev <= 6'h00;
	endtask : pulse

	// ****************************************************************
	// Scenarios
	// ****************************************************************

	task automatic t_reset;
		rd(8'h04, 32'h0010_0000, "reset dword");
		chk("levels", {26'h0, lvl}, 32'h0000_0000);
		gate(4'b1101, 4'b1110, 3'b001, 3'b000);
		gate(4'b1010, 4'b0001, 3'b001, 3'b000);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_command;
		wr(4'b0011, 32'h0000_FFFF);
		rd(8'h04, 32'h0010_0157, "command readback");
		chk("levels", {26'h0, lvl}, 32'h0000_003F);
		gate(4'b1101, 4'b1111, 3'b110, 3'b111);
		gate(4'b1010, 4'b0000, 3'b100, 3'b000);
		wr(4'b0011, 32'h0000_0006);
		wr(4'b1100, 32'h0000_FFFF);
		rd(8'h04, 32'h0010_0006, "lane select");
		gate(4'b1101, 4'b1110, 3'b100, 3'b110);
		$display("t_command done");
	endtask : t_command

	task automatic t_events;
		wr(4'b0011, 32'h0000_0157);
		pulse(6'h3F);
		rd(8'h04, 32'hF910_0157, "all flags");
		wr(4'b1100, 32'h0000_0000);
		rd(8'h04, 32'hF910_0157, "zero write");
		host.clear_flags(16'h8800);
		rd(8'h04, 32'h7110_0157, "partial clear");
		host.clear_flags(16'hFFFF);
		rd(8'h04, 32'h0010_0157, "full clear");
		wr(4'b0011, 32'h0000_0000);
		pulse(6'h23);
		rd(8'h04, 32'h8010_0000, "gated flags");
		host.clear_flags(16'h8000);
		rd(8'h04, 32'h0010_0000, "poison cleared");
		// A clear and a new event taken at the same edge: the event must survive.
		fork
			host.clear_flags(16'h8000);
			pulse(6'h01);
		join
		rd(8'h04, 32'h8010_0000, "set beats clear");
		$display("t_events done");
	endtask : t_events

	task automatic t_unmapped_reset;
		rd(8'h08, 32'h0000_0000, "unmapped read");
		wr(4'b0011, 32'h0000_0007);
		chk("levels before reset", {26'h0, lvl}, 32'h0000_001C);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'h04, 32'h0010_0000, "second reset");
		chk("levels after reset", {26'h0, lvl}, 32'h0000_0000);
		$display("t_unmapped_reset done");
	endtask : t_unmapped_reset

	task automatic test_done;
		$display("Checks %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	// Main sequence after a 20-cycle reset.
	initial begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_command();
		t_events();
		t_unmapped_reset();
		test_done();
	end

	// Watchdog well beyond the roughly 80 cycles the reset and scenarios take.
	initial begin
		repeat (4000) @(posedge core_clk);
		fails++;
		test_done();
	end
endmodule : pcie_bridge_cmd_status_regs_tb_top
